/* File: bench/tb_watchdog_and_standby_wakeup.sv */
// Register-level testbench for the watchdog and standby block
`timescale 1ns/100ps
`include "wds_defs.vh"
module tb_watchdog_and_standby_wakeup;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic low_speed_rc_osc_tick = 1'b0;
  logic halt_instr = 1'b0;
  logic watchdog_clear_instruction_instr = 1'b0;
  logic [3:0] port_a = 4'hf;
  logic [7:0] irq_req = 8'h00;
  logic [7:0] irq_enable = 8'h00;
  logic stack_full = 1'b0;
  wire pready;
  wire pslverr;
  wire [31:0] prdata;
  wire standby;
  wire [1:0] standby_mode;
  wire fast_clk_en;
  wire low_speed_rc_osc_run;
  wire device_reset;
  wire pc_sp_reset;
  wire resume_next;
  wire irq_response;
  logic [31:0] rq;
  logic re;
  int failures = 0;
  int n_checks = 0;
  int n_rst = 0, n_pcsp = 0, n_res = 0, n_irq = 0;
  int e_rst = 0, e_pcsp = 0, e_res = 0, e_irq = 0;
  int lim;
  wds_top #(.NPIN(4), .NIRQ(8), .KEY_FAULT_TICKS(2)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .low_speed_rc_osc_tick(low_speed_rc_osc_tick), .halt_instr(halt_instr),
    .watchdog_clear_instruction_instr(watchdog_clear_instruction_instr), .port_a(port_a), .irq_req(irq_req),
    .irq_enable(irq_enable), .stack_full(stack_full), .standby(standby),
    .standby_mode(standby_mode), .fast_clk_en(fast_clk_en),
    .low_speed_rc_osc_run(low_speed_rc_osc_run), .device_reset(device_reset),
    .pc_sp_reset(pc_sp_reset), .resume_next(resume_next),
    .irq_response(irq_response));
  // 125 MHz clock
  always #4 pclk = ~pclk;
  // Count every pulse so short ones cannot slip between checks
  always @(posedge pclk)
  begin
    n_rst <= n_rst + device_reset;
    n_pcsp <= n_pcsp + pc_sp_reset;
    n_res <= n_res + resume_next;
    n_irq <= n_irq + irq_response;
  end
  // ==========================================
  // Tasks
  task stop_test;
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, exp, got);
    end
  endtask
  // Zero-wait slave, but the wait loop keeps the master honest
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rq, e);
  endtask
  task tick(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      low_speed_rc_osc_tick <= 1'b1;
      @(posedge pclk);
      low_speed_rc_osc_tick <= 1'b0;
    end
    repeat (2)
      @(posedge pclk);
  endtask
  task pulse(input logic h);
    @(posedge pclk);
    halt_instr <= h;
    watchdog_clear_instruction_instr <= !h;
    @(posedge pclk);
    halt_instr <= 1'b0;
    watchdog_clear_instruction_instr <= 1'b0;
    repeat (2)
      @(posedge pclk);
  endtask
  task cnts;
    chk("resets", n_rst, e_rst);
    chk("pc_sp", n_pcsp, e_pcsp);
    chk("resumes", n_res, e_res);
    chk("irq_resp", n_irq, e_irq);
  endtask
  // Pending bits stay set through the halt and must not wake
  task irq_wake(input logic [7:0] pend, input int b, input logic f);
    irq_req <= pend;
    irq_enable <= 8'h02;
    stack_full <= f;
    pulse(1'b1);
    repeat (3)
      @(posedge pclk);
    chk("pend_stby", standby, 1'b1);
    irq_req <= pend | (8'h01 << b);
    repeat (3)
      @(posedge pclk);
    irq_req <= 8'h00;
  endtask
  // ==========================================
  // Watchdog for a hung run
  initial
  begin
    #720000;
    failures++;
    stop_test;
  end
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (5)
      @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl", `WDS_OFF_CTRL, 32'h53);
    rd("flags", `WDS_OFF_FLAGS, 32'h0);
    rd("status", `WDS_OFF_STATUS, 32'h8);
    rd("unmapped", 12'h020, 32'h0);
    chk("slverr", re, 1'b1);
    // Read back every select code; time the short ones
    for (int s = 0; s < 8; s++)
    begin
      apb(1'b1, `WDS_OFF_CTRL, {`WDS_KEY_ON, s[2:0]});
      rd("sel", `WDS_OFF_CTRL, {`WDS_KEY_ON, s[2:0]});
      if (s < 4)
      begin
        lim = 1 << (8 + 2 * s);
        pulse(1'b0);
        tick(lim / 2);
        pulse(1'b0);
        tick(lim - 1);
        cnts;
        tick(1);
        e_rst++;
        cnts;
        rd("run_ovf", `WDS_OFF_STATUS, 32'ha);
      end
    end
    apb(1'b1, `WDS_OFF_CTRL, 32'h50);
    apb(1'b1, `WDS_OFF_PWR, 32'h1);
    tick(3);
    pulse(1'b1);
    chk("mode", standby_mode, `WDS_MODE_FAST_ONLY);
    chk("fast_clk", fast_clk_en, 1'b1);
    chk("low_speed_rc_osc_wdt", low_speed_rc_osc_run, 1'b1);
    rd("halt_st", `WDS_OFF_STATUS, 32'hd);
    rd("halt_cnt", `WDS_OFF_COUNT, 32'h0);
    tick(255);
    cnts;
    tick(1);
    e_pcsp++;
    cnts;
    rd("stby_ovf", `WDS_OFF_STATUS, 32'hb);
    // Disabled watchdog stays stopped in sleep
    apb(1'b1, `WDS_OFF_CTRL, {`WDS_KEY_OFF, 3'h0});
    apb(1'b1, `WDS_OFF_PWR, 32'h0);
    apb(1'b1, `WDS_OFF_WAKE, 32'h1);
    pulse(1'b1);
    chk("low_speed_rc_osc_off", low_speed_rc_osc_run, 1'b0);
    tick(300);
    rd("stop_cnt", `WDS_OFF_COUNT, 32'h0);
    port_a <= 4'hd;
    repeat (3)
      @(posedge pclk);
    chk("masked_pin", standby, 1'b1);
    port_a <= 4'hc;
    repeat (3)
      @(posedge pclk);
    e_res++;
    cnts;
    rd("wake_kept", `WDS_OFF_WAKE, 32'h1);
    port_a <= 4'hf;
    irq_wake(8'h01, 1, 1'b0);
    e_irq++;
    cnts;
    irq_wake(8'h00, 2, 1'b0);
    e_res++;
    cnts;
    irq_wake(8'h00, 1, 1'b1);
    e_res++;
    cnts;
    // Bad key resets after two low-speed ticks
    apb(1'b1, `WDS_OFF_CTRL, 32'h53);
    tick(3);
    apb(1'b1, `WDS_OFF_CTRL, 32'h23);
    tick(1);
    cnts;
    tick(1);
    e_rst++;
    cnts;
    rd("kf_flag", `WDS_OFF_FLAGS, 32'h1);
    rd("kf_ctrl", `WDS_OFF_CTRL, 32'h53);
    rd("kf_cnt", `WDS_OFF_COUNT, 32'h0);
    apb(1'b1, `WDS_OFF_FLAGS, 32'h1);
    rd("kf_w1", `WDS_OFF_FLAGS, 32'h1);
    apb(1'b1, `WDS_OFF_FLAGS, 32'h0);
    rd("kf_w0", `WDS_OFF_FLAGS, 32'h0);
    stop_test;
  end
endmodule // tb_watchdog_and_standby_wakeup

/* File: bench/wds_chk.sv */
// Concurrent checks on the watchdog and standby block ports
`timescale 1ns/100ps
`include "wds_defs.vh"
module wds_chk #(
  parameter NPIN = 4,
  parameter NIRQ = 8,
  parameter KEY_FAULT_TICKS = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire halt_instr,
  input wire standby,
  input wire [1:0] standby_mode,
  input wire fast_clk_en,
  input wire low_speed_rc_osc_run,
  input wire device_reset,
  input wire pc_sp_reset,
  input wire resume_next,
  input wire irq_response
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================
  // Standby entry and exit
  sequence halt_s;
    halt_instr && !standby;
  endsequence
  sequence wake_s;
    $fell(standby);
  endsequence
  halt_entry_a: assert property (halt_s |=> standby || device_reset)
    else $error("halt did not enter standby");
  wake_cause_a: assert property (wake_s |-> resume_next || irq_response ||
    pc_sp_reset || device_reset)
    else $error("standby left without a cause");
  resume_exit_a: assert property ((resume_next || irq_response) |->
    $past(standby) && !standby)
    else $error("resume pulse outside a wake");
  pcsp_wake_a: assert property (pc_sp_reset |->
    $past(standby) && !device_reset)
    else $error("pc and sp reset outside standby");
  mode_hold_a: assert property (standby && $past(standby) |->
    $stable(standby_mode))
    else $error("standby mode changed in standby");
  // ==========================================
  // Clock enables and pulses
  run_clocks_a: assert property (!standby |-> fast_clk_en && low_speed_rc_osc_run)
    else $error("clock stopped while running");
  // Only the fast keep-on bit may hold the fast clock
  fast_only_a: assert property (standby |->
    fast_clk_en == standby_mode[1])
    else $error("fast clock enable wrong in standby");
  reset_pulse_a: assert property (device_reset |=> !device_reset)
    else $error("device reset longer than one cycle");
  slverr_phase_a: assert property (pslverr |-> psel && penable && pready)
    else $error("slave error outside access phase");
endmodule // wds_chk
bind wds_top wds_chk #(.NPIN(NPIN), .NIRQ(NIRQ),
  .KEY_FAULT_TICKS(KEY_FAULT_TICKS)) chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .halt_instr(halt_instr), .standby(standby), .standby_mode(standby_mode),
  .fast_clk_en(fast_clk_en), .low_speed_rc_osc_run(low_speed_rc_osc_run),
  .device_reset(device_reset), .pc_sp_reset(pc_sp_reset),
  .resume_next(resume_next), .irq_response(irq_response));

/* File: core/wds_defs.vh */
// Constants for the watchdog and standby wake-up block
`ifndef WDS_DEFS_VH
`define WDS_DEFS_VH
// Register byte offsets
`define WDS_OFF_CTRL 12'h000
`define WDS_OFF_FLAGS 12'h004
`define WDS_OFF_STATUS 12'h008
`define WDS_OFF_PWR 12'h00c
`define WDS_OFF_WAKE 12'h010
`define WDS_OFF_COUNT 12'h014
// Control field layout and values
`define WDS_KEY_HI 7
`define WDS_KEY_LO 3
`define WDS_SEL_HI 2
`define WDS_SEL_LO 0
`define WDS_CTRL_RESET 8'h53
`define WDS_KEY_ON 5'h0a
`define WDS_KEY_OFF 5'h15
// Flag and status bits
`define WDS_FLAG_KEYF 0
`define WDS_ST_PDF 0
`define WDS_ST_EXP 1
`define WDS_ST_STBY 2
`define WDS_ST_EN 3
`define WDS_PWR_FAST 0
`define WDS_PWR_SLOW 1
// Standby modes, coded as {fast, slow} keep-on bits
`define WDS_MODE_SLEEP 2'h0
`define WDS_MODE_IDLE0 2'h1
`define WDS_MODE_IDLE1 2'h3
`define WDS_MODE_FAST_ONLY 2'h2
// Timing
`define WDS_LOW_SPEED_RC_OSC_HZ 32000
`define WDS_KEY_FAULT_TICKS 4
`define WDS_CNT_W 18
`endif

/* File: core/wds_top.v */
// Watchdog timer with standby entry and wake-up control
`timescale 1ns/100ps
`include "wds_defs.vh"
// Function
// - Fast-only standby keeps fast clock, stops slow clock unless watchdog enabled, halts execution.
// - Power-down instruction sets power-down flag and clears expired flag.
// - Standby entry clears counter; it runs only while watchdog enabled.
// - Standby holds memory, registers and port states unchanged.
// - Wake on enabled port A falling edge, interrupt or overflow.
// - Per-pin wake mask; pin wake resumes after power-down instruction.
// - Disabled interrupt or full stack: resume after power-down instruction.
// - Enabled interrupt with free stack: normal interrupt response.
// - Interrupt already pending at entry does not wake.
// - Counter advances only on low-speed RC clock ticks.
// - Period select gives 2^8,10,12,14,15,16,17,18 tick timeouts.
// - Key 01010 enables, 10101 disables, others reset after delay.
// - Key-fault reset sets key-fault flag; software writes 0 to clear.
// - After power-on key is 01010 and period select is 011.
// - Overflow in run mode resets device, sets expired, keeps pdf.
// - Overflow in standby sets both flags, resets pc and sp only.
// - Clear instruction, power-down and key-fault reset clear counter.
// - Fast keep-on 1 with slow keep-on 0 selects fast-only standby.
// - Low-speed oscillator runs whenever watchdog is enabled.
module wds_top #(
  parameter NPIN = 4,
  parameter NIRQ = 8,
  parameter KEY_FAULT_TICKS = `WDS_KEY_FAULT_TICKS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire low_speed_rc_osc_tick,
  input wire halt_instr,
  input wire watchdog_clear_instruction_instr,
  input wire [NPIN-1:0] port_a,
  input wire [NIRQ-1:0] irq_req,
  input wire [NIRQ-1:0] irq_enable,
  input wire stack_full,
  output wire standby,
  output wire [1:0] standby_mode,
  output wire fast_clk_en,
  output wire low_speed_rc_osc_run,
  output reg device_reset,
  output reg pc_sp_reset,
  output reg resume_next,
  output reg irq_response
);

  // ===========================================================
  // Constants and helpers
  // ===========================================================
  localparam [`WDS_CNT_W-1:0] ONE = 18'h00001;
  localparam [7:0] KF_TICKS = KEY_FAULT_TICKS[7:0];

  // Terminal count for each period select code
  function [`WDS_CNT_W-1:0] wds_limit;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: wds_limit = 18'h000ff;
        3'h1: wds_limit = 18'h003ff;
        3'h2: wds_limit = 18'h00fff;
        3'h3: wds_limit = 18'h03fff;
        3'h4: wds_limit = 18'h07fff;
        3'h5: wds_limit = 18'h0ffff;
        3'h6: wds_limit = 18'h1ffff;
        default: wds_limit = 18'h3ffff;
      endcase
    end
  endfunction

  // ===========================================================
  // Register state
  // ===========================================================
  reg [7:0] watchdog_control;
  reg watchdog_key_fault_flag;
  reg power_down_flag;
  reg watchdog_expired_flag;
  reg fast_osc_keep_on;
  reg slow_osc_keep_on;
  reg [NPIN-1:0] port_wake_mask;
  reg [`WDS_CNT_W-1:0] count;
  reg in_standby;
  reg [1:0] mode;
  reg [NIRQ-1:0] irq_masked;
  reg [NPIN-1:0] port_prev;
  reg [7:0] fault_cnt;

  wire [4:0] watchdog_enable_key;
  wire [2:0] watchdog_period_select;
  wire wdt_on;
  wire key_bad;
  wire wr_cycle;
  wire rd_setup;
  wire mapped;
  wire [31:0] next_rdata;

  assign watchdog_enable_key =
    watchdog_control[`WDS_KEY_HI:`WDS_KEY_LO];
  assign watchdog_period_select =
    watchdog_control[`WDS_SEL_HI:`WDS_SEL_LO];

  assign wdt_on = watchdog_enable_key == `WDS_KEY_ON;
  assign key_bad = !wdt_on &&
    watchdog_enable_key != `WDS_KEY_OFF;

  // ===========================================================
  // APB slave
  // ===========================================================
  // Zero wait states; read data captured in the setup cycle
  assign pready = 1'b1;
  assign mapped = paddr == `WDS_OFF_CTRL ||
    paddr == `WDS_OFF_FLAGS || paddr == `WDS_OFF_STATUS ||
    paddr == `WDS_OFF_PWR || paddr == `WDS_OFF_WAKE ||
    paddr == `WDS_OFF_COUNT;
  assign pslverr = psel && penable && !mapped;
  assign wr_cycle = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;

  // Read multiplexer
  assign next_rdata =
    (paddr == `WDS_OFF_CTRL) ? {24'h0, watchdog_control} :
    (paddr == `WDS_OFF_FLAGS) ?
      {31'h0, watchdog_key_fault_flag} :
    (paddr == `WDS_OFF_STATUS) ?
      {28'h0, wdt_on, in_standby, watchdog_expired_flag,
       power_down_flag} :
    (paddr == `WDS_OFF_PWR) ?
      {30'h0, slow_osc_keep_on, fast_osc_keep_on} :
    (paddr == `WDS_OFF_WAKE) ?
      {{(32-NPIN){1'b0}}, port_wake_mask} :
    (paddr == `WDS_OFF_COUNT) ? {14'h0, count} :
    32'h0;

  // Read data register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (rd_setup)
      prdata <= next_rdata;
  end

  // ===========================================================
  // Wake sources
  // ===========================================================
  wire [NPIN-1:0] pin_fall;
  wire [NIRQ-1:0] irq_new;
  wire irq_wake;
  wire pin_wake;
  wire irq_serve;
  wire tick_run;
  wire overflow;
  wire entering;

  // per-pin falling edge gated by its wake bit
  assign pin_fall = port_prev & ~port_a & port_wake_mask;
  assign pin_wake = |pin_fall;
  // requests pending at entry are masked off
  assign irq_new = irq_req & ~irq_masked;
  assign irq_wake = |irq_new;
  // serviceable only if enabled and stack has room
  assign irq_serve = |(irq_new & irq_enable) && !stack_full;

  // counter moves only on low-speed ticks
  assign tick_run = low_speed_rc_osc_tick && wdt_on;
  // timeout at selected power of two
  assign overflow = tick_run && !watchdog_clear_instruction_instr &&
    count == wds_limit(watchdog_period_select);
  assign entering = halt_instr && !in_standby;

  // Previous port sample for edge detection
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_prev <= {NPIN{1'b0}};
    else
      port_prev <= port_a;
  end

  // ===========================================================
  // Clock enables and hold
  // ===========================================================
  // fast clock kept only when its keep-on bit is set
  assign fast_clk_en = !in_standby || mode[1];
  // slow oscillator forced on by an enabled watchdog
  assign low_speed_rc_osc_run = !in_standby || mode[0] || wdt_on;
  // core, memories and ports freeze while this is high
  assign standby = in_standby;
  assign standby_mode = mode;

  // ===========================================================
  // Standby state and wake decision
  // ===========================================================
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_standby <= 1'b0;
      mode <= `WDS_MODE_SLEEP;
      irq_masked <= {NIRQ{1'b0}};
      resume_next <= 1'b0;
      irq_response <= 1'b0;
    end
    else
    begin
      resume_next <= 1'b0;
      irq_response <= 1'b0;
      if (entering)
      begin
        in_standby <= 1'b1;
        // mode from the two keep-on bits
        mode <= {fast_osc_keep_on, slow_osc_keep_on};
        irq_masked <= irq_req;
      end
      else if (in_standby)
      begin
        // overflow wins, then interrupt, then pin
        if (overflow)
          in_standby <= 1'b0;
        else if (irq_wake)
        begin
          in_standby <= 1'b0;
          // otherwise fall through to next instruction
          if (irq_serve)
            irq_response <= 1'b1;
          else
            resume_next <= 1'b1;
        end
        else if (pin_wake)
        begin
          // pin wake resumes after the halt
          in_standby <= 1'b0;
          resume_next <= 1'b1;
        end
      end
    end
  end

  // ===========================================================
  // Watchdog counter and key fault delay
  // ===========================================================
  // Fault delay counts ticks too, so it tracks the slow clock
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= {`WDS_CNT_W{1'b0}};
      fault_cnt <= 8'h0;
      device_reset <= 1'b0;
      pc_sp_reset <= 1'b0;
    end
    else
    begin
      device_reset <= 1'b0;
      pc_sp_reset <= 1'b0;
      // tick count before the key-fault reset
      if (!key_bad)
        fault_cnt <= 8'h0;
      else if (low_speed_rc_osc_tick)
        fault_cnt <= fault_cnt + 8'h01;
      if (key_bad && low_speed_rc_osc_tick && fault_cnt + 8'h01 >= KF_TICKS)
      begin
        count <= {`WDS_CNT_W{1'b0}};
        fault_cnt <= 8'h0;
        device_reset <= 1'b1;
      end
      // entry clears; disabled watchdog then stays at 0
      else if (entering || watchdog_clear_instruction_instr)
        count <= {`WDS_CNT_W{1'b0}};
      else if (overflow)
      begin
        count <= {`WDS_CNT_W{1'b0}};
        // run mode overflow: full device reset
        // standby overflow: pc and sp only
        if (in_standby)
          pc_sp_reset <= 1'b1;
        else
          device_reset <= 1'b1;
      end
      else if (tick_run)
        count <= count + ONE;
    end
  end

  wire fault_fire;
  assign fault_fire = key_bad && low_speed_rc_osc_tick &&
    fault_cnt + 8'h01 >= KF_TICKS;

  // ===========================================================
  // Software registers
  // ===========================================================
  // Key fault reloads the control word, else it would refire
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      watchdog_control <= `WDS_CTRL_RESET;
      fast_osc_keep_on <= 1'b0;
      slow_osc_keep_on <= 1'b0;
      port_wake_mask <= {NPIN{1'b0}};
    end
    else
    begin
      if (fault_fire)
        watchdog_control <= `WDS_CTRL_RESET;
      else if (wr_cycle && paddr == `WDS_OFF_CTRL)
        watchdog_control <= pwdata[7:0];
      if (wr_cycle && paddr == `WDS_OFF_PWR)
      begin
        fast_osc_keep_on <= pwdata[`WDS_PWR_FAST];
        slow_osc_keep_on <= pwdata[`WDS_PWR_SLOW];
      end
      if (wr_cycle && paddr == `WDS_OFF_WAKE)
        port_wake_mask <= pwdata[NPIN-1:0];
    end
  end

  // Key fault flag: set beats a software clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      watchdog_key_fault_flag <= 1'b0;
    else if (fault_fire)
      watchdog_key_fault_flag <= 1'b1;
    // only a write of 0 clears
    else if (wr_cycle && paddr == `WDS_OFF_FLAGS &&
             !pwdata[`WDS_FLAG_KEYF])
      watchdog_key_fault_flag <= 1'b0;
  end

  // ===========================================================
  // Status flags
  // ===========================================================
  // pdf cleared only by power-on, expired also by halt; read-only to software
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_down_flag <= 1'b0;
      watchdog_expired_flag <= 1'b0;
    end
    // halt sets pdf and clears expired
    else if (entering)
    begin
      power_down_flag <= 1'b1;
      watchdog_expired_flag <= 1'b0;
    end
    else if (overflow)
    begin
      // pdf left as is in run mode
      watchdog_expired_flag <= 1'b1;
      if (in_standby)
        power_down_flag <= 1'b1;
    end
  end

endmodule // wds_top
